// ===== dv/frame_source.sv
/* ingress pipeline model: offers one frame descriptor and holds it until taken.
   assumes a single clock and a combinational ready from the classifier. */
`timescale 1ns/100ps
module frame_source (
   input wire logic clk_in, // clock
   input wire logic ready_in, // classifier idle
   output logic valid_out, // descriptor offered
   output logic [15:0] len_type_out, // length/type field
   output logic [1:0] class_out // frame class
);
   initial begin
      valid_out = 1'b0;
      len_type_out = 16'h0000;
      class_out = 2'h0;
   end
   // released fields are inverted so a late sample cannot pass by luck
   task automatic offer(input logic [15:0] lt, input logic [1:0] cl);
      @(posedge clk_in);
      valid_out <= 1'b1;
      len_type_out <= lt;
      class_out <= cl;
      @(negedge clk_in);
      while (ready_in !== 1'b1) @(negedge clk_in);
      @(posedge clk_in);
      valid_out <= 1'b0;
      len_type_out <= ~lt;
      class_out <= ~cl;
   endtask
endmodule // frame_source

// ===== dv/tb_acl_entry_frame_classifier.sv
/* self-checking bench for the classifier: register port, frames, interrupt.
   assumes the descriptor source model and the package of the design. */
`timescale 1ns/100ps
module tb_acl_entry_frame_classifier;
   import acl_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, fv, rv, rh, rdrop, rredir, rmir, irq;
   logic fr, rfwd, rlrn, rlog, rshut, elog = 1'b0, eshut = 1'b0;
   logic [13:0] flen = 14'h0000;
   logic [15:0] pdown;
   logic [7:0] addr = 8'h00, pol = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, seed = 32'hE838E74A;
   logic [47:0] mac = 48'h0;
   logic [15:0] lt, flt;
   logic [1:0] fcl;
   logic [3:0] rport;
   logic [4:0] rlim;
   logic [8:0] ridx;
   int error_cnt = 0, check_count = 0, hits0 = 0;
   always #5 clk = ~clk;
   frame_source src_u (.clk_in(clk), .ready_in(fr), .valid_out(fv), .len_type_out(flt), .class_out(fcl));
   acl_entry_frame_classifier dut_u (.MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata),
      .WR_STB_IN(wr_s), .RD_STB_IN(rd_s), .RD_DATA_OUT(rdata), .FRM_VALID_IN(fv), .FRM_READY_OUT(fr),
      .FRM_PORT_IN(pol[3:0]), .FRM_POLICY_IN(pol), .FRM_LEN_TYPE_IN(flt), .FRM_CLASS_IN(fcl),
      .FRM_SOURCE_MAC_ADDRESS_IN(mac), .FRM_DESTINATION_MAC_ADDRESS_IN(~mac), .FRM_LEN_IN(flen), .RES_VALID_OUT(rv), .RES_HIT_OUT(rh),
      .RES_ENTRY_OUT(ridx), .RES_DROP_OUT(rdrop), .RES_FWD_OUT(rfwd), .RES_LEARN_OUT(rlrn),
      .RES_LIMITER_OUT(rlim), .RES_REDIRECT_OUT(rredir), .RES_REDIRECT_PORT_OUT(rport), .RES_MIRROR_OUT(rmir),
      .RES_LOG_OUT(rlog), .RES_SHUTDOWN_OUT(rshut), .PORT_DOWN_OUT(pdown), .IRQ_OUT(irq));
   // xorshift keeps the random stream repeatable from the fixed seed
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (!ok) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk(rdata === e, "read data");
   endtask
   // entry 0 drops type coded frames, entry 1 catches everything else
   task automatic frame(input logic [15:0] t, input logic [1:0] cl, input logic hit, input int idx);
      int n = 0;
      src_u.offer(t, cl);
      do begin
         @(negedge clk);
         n++;
      end while (rv !== 1'b1 && n < 600);
      chk(n == (hit ? idx + 3 : 514) && (!hit || ridx === 9'(idx)), "latency or index");
      chk(rh === hit && rdrop === (hit && idx == 0), "hit or drop");
      chk(rlim === ((hit && idx == 1) ? 5'h10 : 5'h00), "limiter");
      chk(rredir === (hit && idx == 1) && (!rredir || rport === 4'h5), "redirect");
      chk(rmir === (hit && idx == 0), "mirror");
      chk(rfwd === !(hit && idx == 0) && rlrn === rfwd, "forward or learn");
      chk(rlog === elog && rshut === eshut, "log or shutdown");
      if (hit && idx == 0) hits0++;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      results();
   end
   initial begin
      mac <= 48'({rnd(), rnd()}) & 48'hFEFFFFFFFFFF;
      pol <= 8'(rnd());
      flen <= 14'(rnd());
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      wr(A_IRQ_ENABLE, 32'h1);
      wr(A_ENTRY_SEL, 32'h0);
      wr(A_ENTRY_CTRL, 32'h08100240);
      wr(A_ENTRY_SEL, 32'h1);
      wr(A_ENTRY_CTRL, 32'h0805C000);
      frame(16'h0600, 2'h0, 1'b1, 0);
      frame(16'h05FF, 2'h0, 1'b1, 1);
      frame(16'h0806, 2'h1, 1'b1, 1);
      for (int i = 0; i < 6; i++) begin
         lt = 16'(rnd());
         frame(lt, 2'(i % 4), 1'b1, (lt >= TYPE_CODE_MIN && i % 4 == 0) ? 0 : 1);
      end
      rd(A_IRQ_STATUS, 32'h1);
      chk(irq === 1'b1, "irq set");
      wr(A_IRQ_CLEAR, 32'h1);
      @(negedge clk);
      chk(irq === 1'b0, "irq clear");
      wr(A_ENTRY_CTRL, 32'h0);
      frame(16'h0800, 2'h2, 1'b0, 0);
      wr(A_ENTRY_SEL, 32'h0);
      rd(A_HIT_COUNT, 32'(hits0));
      // entry 2: arp on one port, policy under mask, source address, multicast; logs and shuts
      wr(A_ENTRY_SEL, 32'h2);
      wr(A_ENTRY_POLICY, {16'h0000, 8'hF0, pol ^ 8'h0F});
      wr(A_SOURCE_MAC_ADDRESS_LO, mac[31:0]);
      wr(A_SOURCE_MAC_ADDRESS_HI, {16'h0000, mac[47:32]});
      wr(A_ENTRY_CTRL, 32'h09E000A1 | {27'h0, pol[3:0], 1'b0});
      flen <= 14'h0040;
      elog = 1'b1;
      eshut = 1'b1;
      frame(16'h0806, 2'h1, 1'b1, 2);
      chk(pdown === (16'h0001 << pol[3:0]), "port down");
      elog = 1'b0;
      frame(16'h0806, 2'h1, 1'b1, 2);
      flen <= 14'h05EE;
      eshut = 1'b0;
      frame(16'h0806, 2'h1, 1'b1, 2);
      rd(A_IRQ_STATUS, 32'h6);
      rd(A_HIT_COUNT, 32'h3);
      wr(A_HIT_COUNT, 32'h0);
      rd(A_HIT_COUNT, 32'h0);
      wr(A_PORT_DOWN, 32'(pdown));
      @(negedge clk);
      chk(pdown === 16'h0000, "port up");
      rd(8'h3C, 32'h0);
      results();
   end
endmodule // tb_acl_entry_frame_classifier

// ===== hdl/acl_entry_frame_classifier.sv
/*
 * access control entry frame classifier: holds the access_control_list, scans it
 * for each frame descriptor and reports the first hit entry's actions.
 * assumes the ingress pipeline offers one descriptor at a time on the same clock
 * and that software reaches the entry table over the simple register port.
 */
`timescale 1ns/100ps
module acl_entry_frame_classifier
   import acl_pkg::*;
(
   input wire logic MCLK_IN, // 100 MHz clock
   input wire logic RST_N_IN, // async reset, active low
   input wire logic [7:0] ADDR_IN, // register byte address
   input wire logic [31:0] WR_DATA_IN, // register write data
   input wire logic WR_STB_IN, // write strobe
   input wire logic RD_STB_IN, // read strobe
   output logic [31:0] RD_DATA_OUT, // read data, cycle after strobe
   input wire logic FRM_VALID_IN, // frame descriptor offered
   output logic FRM_READY_OUT, // classifier idle, takes descriptor
   input wire logic [PORT_W-1:0] FRM_PORT_IN, // ingress port number
   input wire logic [7:0] FRM_POLICY_IN, // ingress policy number
   input wire logic [15:0] FRM_LEN_TYPE_IN, // length/type field
   input wire logic [1:0] FRM_CLASS_IN, // other, arp, ipv4, ipv6
   input wire logic [47:0] FRM_SOURCE_MAC_ADDRESS_IN, // source address
   input wire logic [47:0] FRM_DESTINATION_MAC_ADDRESS_IN, // destination address
   input wire logic [13:0] FRM_LEN_IN, // length without vlan tags
   output logic RES_VALID_OUT, // result pulse
   output logic RES_HIT_OUT, // an entry was hit
   output logic [IDX_W-1:0] RES_ENTRY_OUT, // index of hit entry
   output logic RES_DROP_OUT, // frame dropped
   output logic RES_FWD_OUT, // frame may be forwarded
   output logic RES_LEARN_OUT, // source may be learned
   output logic [4:0] RES_LIMITER_OUT, // 0 none, else limiter number
   output logic RES_REDIRECT_OUT, // redirect to port
   output logic [PORT_W-1:0] RES_REDIRECT_PORT_OUT, // redirect port
   output logic RES_MIRROR_OUT, // copy to mirror port, unpoliced
   output logic RES_LOG_OUT, // report to system log
   output logic RES_SHUTDOWN_OUT, // ingress port disabled by this frame
   output logic [PORT_COUNT-1:0] PORT_DOWN_OUT, // ports held disabled
   output logic IRQ_OUT // level interrupt
);
   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // destination address filter
   function automatic logic destination_mac_address_ok(input logic [2:0] sel, input logic [47:0] mac, input logic [47:0] want);
      logic bcast;
      bcast = (mac == MAC_BCAST);
      case (sel)
         DF_ANY: destination_mac_address_ok = 1'b1;
         DF_MULTICAST_ONLY: destination_mac_address_ok = mac[MAC_GROUP_BIT] && !bcast;
         DF_BROADCAST_ONLY: destination_mac_address_ok = bcast;
         DF_UNICAST_ONLY: destination_mac_address_ok = !mac[MAC_GROUP_BIT];
         DF_SPECIFIC: destination_mac_address_ok = (mac == want);
         default: destination_mac_address_ok = 1'b0;
      endcase
   endfunction

   // frame type against entry type; arp and ip stay off type coded entries
   function automatic logic type_ok(input logic [2:0] ft, input logic [1:0] fc, input logic [15:0] lt);
      case (ft)
         FT_ANY: type_ok = 1'b1;
         FT_TYPE_CODED: type_ok = (fc == FC_OTHER) && (lt >= TYPE_CODE_MIN);
         FT_ARP: type_ok = (fc == FC_ARP);
         FT_IPV4: type_ok = (fc == FC_IPV4);
         FT_IPV6: type_ok = (fc == FC_IPV6);
         default: type_ok = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_mem [ENTRY_COUNT];
   logic [15:0] pol_mem [ENTRY_COUNT];
   logic [47:0] source_mac_address_mem [ENTRY_COUNT];
   logic [47:0] destination_mac_address_mem [ENTRY_COUNT];
   logic [31:0] hit_mem [ENTRY_COUNT];
   logic [IDX_W-1:0] sel_reg;
   logic [EV_W-1:0] irq_stat_reg, irq_en_reg;
   logic [PORT_COUNT-1:0] port_down_reg;
   scan_state_e state_reg;
   logic [IDX_W-1:0] scan_idx_reg;
   logic [PORT_W-1:0] f_port_reg;
   logic [7:0] f_pol_reg;
   logic [15:0] f_lt_reg;
   logic [1:0] f_class_reg;
   logic [47:0] f_source_mac_address_reg, f_destination_mac_address_reg;
   logic [13:0] f_len_reg;
   logic found_reg;
   logic [IDX_W-1:0] found_idx_reg;
   logic [$clog2(LOG_GAP_CYC+1)-1:0] log_gap_reg;
   logic [31:0] rd_data_reg;
   logic res_valid_reg, res_hit_reg, res_drop_reg, res_fwd_reg, res_learn_reg;
   logic res_rdir_reg, res_mirror_reg, res_log_reg, res_shut_reg;
   logic [IDX_W-1:0] res_entry_reg;
   logic [4:0] res_lim_reg;
   logic [PORT_W-1:0] res_rdir_port_reg;

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   // one write strobe per target keeps the storage process short
   wire wr_sel = WR_STB_IN && (ADDR_IN == A_ENTRY_SEL);
   wire wr_ctrl = WR_STB_IN && (ADDR_IN == A_ENTRY_CTRL);
   wire wr_pol = WR_STB_IN && (ADDR_IN == A_ENTRY_POLICY);
   wire wr_source_mac_address_lo = WR_STB_IN && (ADDR_IN == A_SOURCE_MAC_ADDRESS_LO);
   wire wr_source_mac_address_hi = WR_STB_IN && (ADDR_IN == A_SOURCE_MAC_ADDRESS_HI);
   wire wr_destination_mac_address_lo = WR_STB_IN && (ADDR_IN == A_DESTINATION_MAC_ADDRESS_LO);
   wire wr_destination_mac_address_hi = WR_STB_IN && (ADDR_IN == A_DESTINATION_MAC_ADDRESS_HI);
   wire wr_hit_clr = WR_STB_IN && (ADDR_IN == A_HIT_COUNT);
   wire wr_irq_clr = WR_STB_IN && (ADDR_IN == A_IRQ_CLEAR);
   wire wr_irq_en = WR_STB_IN && (ADDR_IN == A_IRQ_ENABLE);
   wire wr_port_up = WR_STB_IN && (ADDR_IN == A_PORT_DOWN);

   // read mux; unmapped addresses and the write-only clear read as zero
   logic [31:0] rd_mux;
   always_comb begin
      case (ADDR_IN)
         A_ENTRY_SEL: rd_mux = {{(32-IDX_W){1'b0}}, sel_reg};
         A_ENTRY_CTRL: rd_mux = {{(32-CTRL_W){1'b0}}, ctrl_mem[sel_reg]};
         A_ENTRY_POLICY: rd_mux = {16'h0000, pol_mem[sel_reg]};
         A_SOURCE_MAC_ADDRESS_LO: rd_mux = source_mac_address_mem[sel_reg][31:0];
         A_SOURCE_MAC_ADDRESS_HI: rd_mux = {16'h0000, source_mac_address_mem[sel_reg][47:32]};
         A_DESTINATION_MAC_ADDRESS_LO: rd_mux = destination_mac_address_mem[sel_reg][31:0];
         A_DESTINATION_MAC_ADDRESS_HI: rd_mux = {16'h0000, destination_mac_address_mem[sel_reg][47:32]};
         A_HIT_COUNT: rd_mux = hit_mem[sel_reg];
         A_IRQ_STATUS: rd_mux = {{(32-EV_W){1'b0}}, irq_stat_reg};
         A_IRQ_ENABLE: rd_mux = {{(32-EV_W){1'b0}}, irq_en_reg};
         A_PORT_DOWN: rd_mux = {{(32-PORT_COUNT){1'b0}}, port_down_reg};
         A_CLASS_STATUS: rd_mux = {{(31-IDX_W){1'b0}}, found_idx_reg, state_reg != ST_IDLE};
         default: rd_mux = 32'h00000000;
      endcase
   end
   wire [31:0] rd_data_next = RD_STB_IN ? rd_mux : 32'h00000000;

   // ---------------------------------------------------------------
   // match of the entry under the scan pointer
   // ---------------------------------------------------------------
   wire [CTRL_W-1:0] ce = ctrl_mem[scan_idx_reg];
   wire [7:0] pol_val = pol_mem[scan_idx_reg][POL_MASK_LO-1:0];
   wire [7:0] pol_mask = pol_mem[scan_idx_reg][POL_MASK_LO+7:POL_MASK_LO];
   wire [2:0] ce_type = ce[F_TYPE_LO+2:F_TYPE_LO];
   wire port_ok = !ce[F_PORT_SPEC] || (ce[F_PORT_LO+PORT_W-1:F_PORT_LO] == f_port_reg);
   wire pol_ok = !ce[F_POL_SPEC] || (((f_pol_reg ^ pol_val) & pol_mask) == 8'h00);
   wire source_mac_address_used = ce[F_SOURCE_MAC_ADDRESS_SPEC] && ((ce_type == FT_TYPE_CODED) || (ce_type == FT_ARP));
   wire source_mac_address_ok = !source_mac_address_used || (f_source_mac_address_reg == source_mac_address_mem[scan_idx_reg]);
   wire d_ok = destination_mac_address_ok(ce[F_DESTINATION_MAC_ADDRESS_LO+2:F_DESTINATION_MAC_ADDRESS_LO], f_destination_mac_address_reg, destination_mac_address_mem[scan_idx_reg]);
   wire entry_hit = ce[F_VALID] && port_ok && pol_ok && source_mac_address_ok && d_ok
      && type_ok(ce_type, f_class_reg, f_lt_reg);
   wire scan_last = (scan_idx_reg == IDX_W'(ENTRY_COUNT - 1));
   wire take_frame = FRM_VALID_IN && (state_reg == ST_IDLE);

   // ---------------------------------------------------------------
   // result of the finished scan
   // ---------------------------------------------------------------
   // actions come from the first hit only; a miss forwards and learns normally
   wire [CTRL_W-1:0] fe = ctrl_mem[found_idx_reg];
   wire finish = (state_reg == ST_DONE);
   wire hit_done = finish && found_reg;
   wire permit = !(found_reg && fe[F_DENY]);
   wire short_frame = (f_len_reg < LEN_LIMIT);
   wire log_want = hit_done && fe[F_LOG] && short_frame;
   wire log_fire = log_want && (log_gap_reg == '0);
   wire shut_fire = hit_done && fe[F_SHUT] && short_frame;
   wire [EV_W-1:0] ev_set = {shut_fire, log_fire, hit_done && fe[F_DENY]};

   // ---------------------------------------------------------------
   // entry table, counters and register state
   // ---------------------------------------------------------------
   // software edits go to the selected entry; a hit in the cycle of a clear of that entry counts from zero
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < ENTRY_COUNT; i++) begin
            ctrl_mem[i] <= '0;
            pol_mem[i] <= '0;
            source_mac_address_mem[i] <= '0;
            destination_mac_address_mem[i] <= '0;
            hit_mem[i] <= '0;
         end
         sel_reg <= '0;
      end else begin
         if (wr_sel) sel_reg <= WR_DATA_IN[IDX_W-1:0];
         if (wr_ctrl) ctrl_mem[sel_reg] <= WR_DATA_IN[CTRL_W-1:0];
         if (wr_pol) pol_mem[sel_reg] <= WR_DATA_IN[15:0];
         if (wr_source_mac_address_lo) source_mac_address_mem[sel_reg][31:0] <= WR_DATA_IN;
         if (wr_source_mac_address_hi) source_mac_address_mem[sel_reg][47:32] <= WR_DATA_IN[15:0];
         if (wr_destination_mac_address_lo) destination_mac_address_mem[sel_reg][31:0] <= WR_DATA_IN;
         if (wr_destination_mac_address_hi) destination_mac_address_mem[sel_reg][47:32] <= WR_DATA_IN[15:0];
         if (wr_hit_clr) hit_mem[sel_reg] <= '0;
         if (hit_done) begin
            hit_mem[found_idx_reg] <= ((wr_hit_clr && sel_reg == found_idx_reg) ? 32'h00000000
               : hit_mem[found_idx_reg]) + 32'h00000001;
         end
      end
   end

   // sticky status and port shutdown bits; the hardware set beats a clear
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         irq_stat_reg <= '0;
         irq_en_reg <= '0;
         port_down_reg <= '0;
         rd_data_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_irq_clr ? WR_DATA_IN[EV_W-1:0] : '0)) | ev_set;
         if (wr_irq_en) irq_en_reg <= WR_DATA_IN[EV_W-1:0];
         port_down_reg <= (port_down_reg & ~(wr_port_up ? WR_DATA_IN[PORT_COUNT-1:0] : '0))
            | (shut_fire ? (PORT_COUNT'(1) << f_port_reg) : '0);
         rd_data_reg <= rd_data_next;
      end
   end

   // ---------------------------------------------------------------
   // scan sequencer
   // ---------------------------------------------------------------
   // one entry a cycle in index order, so low indices (reserved ones) always win
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state_reg <= ST_IDLE;
         scan_idx_reg <= '0;
         found_reg <= 1'b0;
         found_idx_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               scan_idx_reg <= '0;
               if (take_frame) begin
                  state_reg <= ST_SCAN;
                  found_reg <= 1'b0;
               end
            end
            ST_SCAN: begin
               scan_idx_reg <= scan_idx_reg + IDX_W'(1);
               if (entry_hit || scan_last) begin
                  state_reg <= ST_DONE;
                  found_reg <= entry_hit;
                  found_idx_reg <= scan_idx_reg;
               end
            end
            ST_DONE: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // descriptor capture, held steady for the whole scan
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         f_port_reg <= '0;
         f_pol_reg <= '0;
         f_lt_reg <= '0;
         f_class_reg <= '0;
         f_source_mac_address_reg <= '0;
         f_destination_mac_address_reg <= '0;
         f_len_reg <= '0;
      end else if (take_frame) begin
         f_port_reg <= FRM_PORT_IN;
         f_pol_reg <= FRM_POLICY_IN;
         f_lt_reg <= FRM_LEN_TYPE_IN;
         f_class_reg <= FRM_CLASS_IN;
         f_source_mac_address_reg <= FRM_SOURCE_MAC_ADDRESS_IN;
         f_destination_mac_address_reg <= FRM_DESTINATION_MAC_ADDRESS_IN;
         f_len_reg <= FRM_LEN_IN;
      end
   end

   // log spacing: after a report further reports are dropped until the gap runs out
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) log_gap_reg <= '0;
      else if (log_fire) log_gap_reg <= ($bits(log_gap_reg))'(LOG_GAP_CYC);
      else if (log_gap_reg != '0) log_gap_reg <= log_gap_reg - 1'b1;
   end

   // ---------------------------------------------------------------
   // result registers
   // ---------------------------------------------------------------
   // the limiter acts on the forwarded frame only; the mirror copy is unpoliced
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         res_valid_reg <= 1'b0;
         res_hit_reg <= 1'b0;
         res_entry_reg <= '0;
         res_drop_reg <= 1'b0;
         res_fwd_reg <= 1'b0;
         res_learn_reg <= 1'b0;
         res_lim_reg <= '0;
         res_rdir_reg <= 1'b0;
         res_rdir_port_reg <= '0;
         res_mirror_reg <= 1'b0;
         res_log_reg <= 1'b0;
         res_shut_reg <= 1'b0;
      end else begin
         res_valid_reg <= finish;
         res_hit_reg <= hit_done;
         res_entry_reg <= found_idx_reg;
         res_drop_reg <= finish && !permit;
         res_fwd_reg <= finish && permit;
         res_learn_reg <= finish && permit;
         res_lim_reg <= (hit_done && permit && fe[F_LIM_LO+4:F_LIM_LO] <= LIMITER_MAX)
            ? fe[F_LIM_LO+4:F_LIM_LO] : 5'h00;
         res_rdir_reg <= hit_done && permit && fe[F_RDIR_EN];
         res_rdir_port_reg <= fe[F_RDIR_LO+PORT_W-1:F_RDIR_LO];
         res_mirror_reg <= hit_done && fe[F_MIRROR];
         res_log_reg <= log_fire;
         res_shut_reg <= shut_fire;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign RD_DATA_OUT = rd_data_reg;
   assign FRM_READY_OUT = (state_reg == ST_IDLE);
   assign RES_VALID_OUT = res_valid_reg;
   assign RES_HIT_OUT = res_hit_reg;
   assign RES_ENTRY_OUT = res_entry_reg;
   assign RES_DROP_OUT = res_drop_reg;
   assign RES_FWD_OUT = res_fwd_reg;
   assign RES_LEARN_OUT = res_learn_reg;
   assign RES_LIMITER_OUT = res_lim_reg;
   assign RES_REDIRECT_OUT = res_rdir_reg;
   assign RES_REDIRECT_PORT_OUT = res_rdir_port_reg;
   assign RES_MIRROR_OUT = res_mirror_reg;
   assign RES_LOG_OUT = res_log_reg;
   assign RES_SHUTDOWN_OUT = res_shut_reg;
   assign PORT_DOWN_OUT = port_down_reg;
   assign IRQ_OUT = |(irq_stat_reg & irq_en_reg);

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   chk_result_within_scan: assert property (
      take_frame |-> ##[3:515] RES_VALID_OUT) else $error("no result after full scan");
   chk_first_hit_stops: assert property (
      (state_reg == ST_SCAN) && entry_hit |=> finish ##1 (RES_HIT_OUT && RES_ENTRY_OUT == $past(scan_idx_reg, 2)))
      else $error("scan did not stop at first hit");
   chk_deny_drops_frame: assert property (
      RES_VALID_OUT && RES_DROP_OUT |-> !RES_FWD_OUT && !RES_LEARN_OUT && RES_HIT_OUT)
      else $error("denied frame not dropped");
   chk_miss_forwards: assert property (
      RES_VALID_OUT && !RES_HIT_OUT |-> RES_FWD_OUT && RES_LEARN_OUT && !RES_MIRROR_OUT)
      else $error("missed frame not forwarded");
   chk_limiter_range: assert property (
      RES_VALID_OUT |-> RES_LIMITER_OUT <= LIMITER_MAX) else $error("limiter out of range");
   chk_hit_counter_step: assert property (
      hit_done && !wr_hit_clr |=> hit_mem[$past(found_idx_reg)] == $past(hit_mem[found_idx_reg]) + 32'h00000001)
      else $error("hit counter did not advance");
   chk_log_spacing: assert property (
      RES_LOG_OUT |=> (!RES_LOG_OUT)[*8]) else $error("log reports too close");
   chk_shut_port_down: assert property (
      RES_SHUTDOWN_OUT |-> PORT_DOWN_OUT[$past(f_port_reg)] && $past(f_len_reg) < LEN_LIMIT)
      else $error("shutdown did not disable port");
   chk_type_coded_len: assert property (
      (state_reg == ST_SCAN) && entry_hit && ce_type == FT_TYPE_CODED |-> f_lt_reg >= TYPE_CODE_MIN
      && f_class_reg == FC_OTHER) else $error("type coded entry hit by wrong frame");
   // a clear in the same cycle must not swallow a fresh event
   chk_irq_level: assert property (
      (ev_set != '0) |=> ((irq_stat_reg & $past(ev_set)) == $past(ev_set))
      && (IRQ_OUT == |(irq_stat_reg & irq_en_reg))) else $error("event lost or interrupt level wrong");

   cov_deny_hit: cover property (RES_VALID_OUT && RES_DROP_OUT);
   cov_miss: cover property (RES_VALID_OUT && !RES_HIT_OUT);
   cov_shutdown: cover property (RES_SHUTDOWN_OUT);
   cov_mirror_redirect: cover property (RES_MIRROR_OUT && RES_REDIRECT_OUT);
endmodule // acl_entry_frame_classifier

// ===== hdl/acl_pkg.sv
/*
 * constants for the access control entry frame classifier: entry field layout,
 * register offsets, frame classes, destination filters and timing counts.
 * assumes a 100 MHz single clock and word-aligned byte addresses.
 */
package acl_pkg;
   // ---------------------------------------------------------------
   // sizes and timing
   // ---------------------------------------------------------------
   localparam int ENTRY_COUNT = 512;
   localparam int IDX_W = 9;
   localparam int PORT_W = 4;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LOG_GAP_NS = 1000;
   localparam int LOG_GAP_CYC = (LOG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] TYPE_CODE_MIN = 16'h0600;
   localparam logic [13:0] LEN_LIMIT = 14'h05EE;
   localparam logic [4:0] LIMITER_MAX = 5'h10;
   localparam logic [47:0] MAC_BCAST = 48'hFFFFFFFFFFFF;
   localparam int MAC_GROUP_BIT = 40;
   // ---------------------------------------------------------------
   // entry control word fields
   // ---------------------------------------------------------------
   localparam int F_PORT_SPEC = 0;
   localparam int F_PORT_LO = 1;
   localparam int F_POL_SPEC = 5;
   localparam int F_TYPE_LO = 6;
   localparam int F_DENY = 9;
   localparam int F_LIM_LO = 10;
   localparam int F_RDIR_EN = 15;
   localparam int F_RDIR_LO = 16;
   localparam int F_MIRROR = 20;
   localparam int F_LOG = 21;
   localparam int F_SHUT = 22;
   localparam int F_SOURCE_MAC_ADDRESS_SPEC = 23;
   localparam int F_DESTINATION_MAC_ADDRESS_LO = 24;
   localparam int F_VALID = 27;
   localparam int CTRL_W = 28;
   localparam int POL_MASK_LO = 8;
   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {FT_ANY = 3'h0, FT_TYPE_CODED = 3'h1, FT_ARP = 3'h2, FT_IPV4 = 3'h3,
      FT_IPV6 = 3'h4} frame_type_e;
   typedef enum logic [1:0] {FC_OTHER = 2'h0, FC_ARP = 2'h1, FC_IPV4 = 2'h2, FC_IPV6 = 2'h3} frame_class_e;
   typedef enum logic [2:0] {DF_ANY = 3'h0, DF_MULTICAST_ONLY = 3'h1, DF_BROADCAST_ONLY = 3'h2,
      DF_UNICAST_ONLY = 3'h3, DF_SPECIFIC = 3'h4} destination_mac_address_filter_e;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_SCAN = 2'h1, ST_DONE = 2'h3} scan_state_e;
   // ---------------------------------------------------------------
   // register byte offsets and bits
   // ---------------------------------------------------------------
   localparam logic [7:0] A_ENTRY_SEL = 8'h00;
   localparam logic [7:0] A_ENTRY_CTRL = 8'h04;
   localparam logic [7:0] A_ENTRY_POLICY = 8'h08;
   localparam logic [7:0] A_SOURCE_MAC_ADDRESS_LO = 8'h0C;
   localparam logic [7:0] A_SOURCE_MAC_ADDRESS_HI = 8'h10;
   localparam logic [7:0] A_DESTINATION_MAC_ADDRESS_LO = 8'h14;
   localparam logic [7:0] A_DESTINATION_MAC_ADDRESS_HI = 8'h18;
   localparam logic [7:0] A_HIT_COUNT = 8'h1C;
   localparam logic [7:0] A_IRQ_STATUS = 8'h20;
   localparam logic [7:0] A_IRQ_CLEAR = 8'h24;
   localparam logic [7:0] A_IRQ_ENABLE = 8'h28;
   localparam logic [7:0] A_PORT_DOWN = 8'h2C;
   localparam logic [7:0] A_CLASS_STATUS = 8'h30;
   localparam int EV_W = 3;
   localparam int EV_DENY = 0;
   localparam int EV_LOG = 1;
   localparam int EV_SHUT = 2;
   localparam int PORT_COUNT = 16;
endpackage
